//--- design/lcr_config_regs.sv
// lockable configuration registers with serial access and pin control
// Notes on behaviour
// (R1) level-1 lock freezes all lockable fields except charge pump and pin select
// (R2) level-1 lock engages at chip-select rise ending the frame that set it
// (R3) engaged level-1 lock, lock bit included, holds until power-on reset
// (R4) soft reset keeps the level-1 lock bit
// (R5) host clears level-0 lock before changing charge pump or pin select
// (R6) soft reset leaves fields under a set lock unchanged
// (R7) switching frequency bits 7:5, 000..011 = 1.8..2.4 MHz, others reserved
// (R8) bit 4 selects low or high main regulator peak threshold
// (R9) spread spectrum bits 3:2, 00 off, else three modulation rates
// (R10) reserved bits read as zero
// (R11) pin codes 000-010 fail output, 011 timer high side, 100 off
// (R12) pin code 101 is wake input with 16 us static filter
// (R13) pin code 110 PWM low side, 111 PWM high side
// (R14) wake-configured pin is a default wake source in fail-safe mode
// (R15) restart and soft reset value of pin select depends on its setting
// (R16) duty 00 off, ff on, else on for value/255 of each period
// (R17) new duty applies only after the running PWM period ends
// (R18) host writes duty before selecting a PWM pin function
// (R19) level-0 lock bit 3 blocks charge pump and pin select changes; restart still drops a timer or PWM pin function to off
// (R20) locked writes are dropped silently, unlocked fields still update
`timescale 1ns/10ps
module lcr_config_regs #(
  parameter int PWM_STEP_CYCLES = 392
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 SYS_RST,
  input  wire logic                 SOFT_RST,
  input  wire logic                 RESTART,
  input  wire logic                 SPI_CS_N,
  input  wire logic                 SPI_SCK,
  input  wire logic                 SPI_SDI,
  output logic                      SPI_SDO,
  output logic                      SPI_SDO_OE,
  input  wire logic                 PIN_IN,
  input  wire logic                 FAIL_REQ,
  input  wire logic                 TIMER_ON,
  input  wire logic                 FAIL_SAFE,
  input  wire logic                 WAKE_ENABLE,
  output lcr_pkg::lcr_hw_cfg_s      HW_CFG,
  output logic                      CHARGE_PUMP_ENABLE,
  output logic [2:0]                PIN_FUNC,
  output logic                      LOCK0_SET,
  output logic                      LOCK1_ACTIVE,
  output logic                      PIN_HS_ON,
  output logic                      PIN_LS_ON,
  output logic                      WAKE_LEVEL,
  output logic                      WAKE_EVENT
);
  // ===========================================================
  // input synchronisers
  logic [1:0] cs_sync, sck_sync, sdi_sync, pin_sync;
  logic       cs_prev, sck_prev;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cs_sync  <= 2'h3;
      sck_sync <= 2'h0;
      sdi_sync <= 2'h0;
      pin_sync <= 2'h0;
      cs_prev  <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      cs_sync  <= {cs_sync[0], SPI_CS_N};
      sck_sync <= {sck_sync[0], SPI_SCK};
      sdi_sync <= {sdi_sync[0], SPI_SDI};
      pin_sync <= {pin_sync[0], PIN_IN};
      cs_prev  <= cs_sync[1];
      sck_prev <= sck_sync[1];
    end
  end
  logic cs_fall, cs_rise, sck_rise, sck_fall;
  assign cs_fall  = cs_prev & ~cs_sync[1];
  assign cs_rise  = ~cs_prev & cs_sync[1];
  assign sck_rise = ~cs_sync[1] & ~sck_prev & sck_sync[1];
  assign sck_fall = ~cs_sync[1] & sck_prev & ~sck_sync[1];
  // ===========================================================
  // register state
  logic [2:0] freq, next_freq;
  logic       peak, next_peak;
  logic [1:0] spread, next_spread;
  logic       lock1_bit, next_lock1_bit;
  logic       lock1_act, next_lock1_act;
  logic       lock0, next_lock0;
  logic       charge_pump_enable, next_charge_pump_enable;
  logic [2:0] pin_func, next_pin_func;
  logic [7:0] duty, next_duty;
  // read view of a register, reserved bits zero
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      lcr_pkg::HWC1_OFS:    d[lcr_pkg::LOCK0_BIT] = lock0;
      lcr_pkg::HWC2_OFS: begin
        d[lcr_pkg::FREQ_LSB +: 3]   = freq;
        d[lcr_pkg::PEAK_BIT]        = peak;
        d[lcr_pkg::SPREAD_LSB +: 2] = spread;
        d[lcr_pkg::LOCK1_BIT]       = lock1_bit;
      end
      lcr_pkg::CP_CTRL_OFS: d[lcr_pkg::CHARGE_PUMP_ENABLE_BIT] = charge_pump_enable;
      lcr_pkg::PINF_OFS:    d[lcr_pkg::PINF_LSB +: 3] = pin_func;
      lcr_pkg::DUTY_OFS:    d = duty;
      default:              d = 8'h00;
    endcase
    return d; // [R10]
  endfunction
  // ===========================================================
  // serial frame: lsb first, addr[6:0], write flag, data[7:0]
  lcr_pkg::lcr_spi_st_e spi_st, next_spi_st;
  logic [4:0]  bit_cnt, next_bit_cnt;
  logic [15:0] rx, next_rx;
  logic [7:0]  tx, next_tx;
  logic        sdo_oe, next_sdo_oe;
  logic        commit;
  assign commit = cs_rise && spi_st == lcr_pkg::SP_SHIFT &&
                  bit_cnt == 5'(lcr_pkg::SPI_FRAME_BITS) && rx[7];
  always_comb begin
    next_spi_st  = spi_st;
    next_bit_cnt = bit_cnt;
    next_rx      = rx;
    next_tx      = tx;
    next_sdo_oe  = ~cs_sync[1];
    if (cs_fall) begin
      next_spi_st  = lcr_pkg::SP_SHIFT;
      next_bit_cnt = 5'h00;
      next_tx      = 8'h00;
    end else if (cs_rise) begin
      next_spi_st = lcr_pkg::SP_IDLE;
    end else if (sck_rise && spi_st == lcr_pkg::SP_SHIFT) begin
      next_rx      = {sdi_sync[1], rx[15:1]};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(lcr_pkg::SPI_FRAME_BITS)) begin
        next_spi_st = lcr_pkg::SP_ERR;
      end
      if (bit_cnt == 5'h07) begin
        next_tx = reg_read(next_rx[14:8]);
      end
    end else if (sck_fall && bit_cnt > 5'h08) begin
      next_tx = {1'b0, tx[7:1]};
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      spi_st  <= lcr_pkg::SP_IDLE;
      bit_cnt <= 5'h00;
      rx      <= 16'h0000;
      tx      <= 8'h00;
      sdo_oe  <= 1'b0;
    end else begin
      spi_st  <= next_spi_st;
      bit_cnt <= next_bit_cnt;
      rx      <= next_rx;
      tx      <= next_tx;
      sdo_oe  <= next_sdo_oe;
    end
  end
  assign SPI_SDO    = tx[0];
  assign SPI_SDO_OE = sdo_oe;
  // ===========================================================
  // register update, soft reset and restart
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  assign wr_addr = rx[6:0];
  assign wr_data = rx[15:8];
  always_comb begin
    next_freq      = freq;
    next_peak      = peak;
    next_spread    = spread;
    next_lock1_bit = lock1_bit;
    next_lock1_act = lock1_act;
    next_lock0     = lock0;
    next_charge_pump_enable     = charge_pump_enable;
    next_pin_func  = pin_func;
    next_duty      = duty;
    if (SOFT_RST) begin
      if (!lock1_bit) begin // [R6]
        next_freq   = lcr_pkg::HWC2_RST[lcr_pkg::FREQ_LSB +: 3];
        next_peak   = lcr_pkg::HWC2_RST[lcr_pkg::PEAK_BIT];
        next_spread = lcr_pkg::HWC2_RST[lcr_pkg::SPREAD_LSB +: 2];
      end
      // lock1 bit and engaged lock stay untouched [R4] [R3]
      if (!lock0) begin // [R6] [R15]
        next_charge_pump_enable    = lcr_pkg::CHARGE_PUMP_ENABLE_RST;
        next_pin_func = lcr_pkg::PINF_RST;
      end
      next_lock0 = lcr_pkg::LOCK0_RST;
      next_duty  = lcr_pkg::DUTY_RST;
    end else if (RESTART) begin
      // switch functions drop to off, others keep their setting [R15]
      if (pin_func == lcr_pkg::PF_TIMER_HS ||
          pin_func == lcr_pkg::PF_PWM_LS ||
          pin_func == lcr_pkg::PF_PWM_HS) begin
        next_pin_func = lcr_pkg::PF_OFF;
      end
    end else if (commit) begin
      case (wr_addr)
        lcr_pkg::HWC1_OFS: next_lock0 = wr_data[lcr_pkg::LOCK0_BIT];
        lcr_pkg::HWC2_OFS: begin
          if (!lock1_act) begin // [R1] [R3] [R20]
            next_freq      = wr_data[lcr_pkg::FREQ_LSB +: 3]; // [R7]
            next_peak      = wr_data[lcr_pkg::PEAK_BIT]; // [R8]
            next_spread    = wr_data[lcr_pkg::SPREAD_LSB +: 2]; // [R9]
            next_lock1_bit = wr_data[lcr_pkg::LOCK1_BIT];
          end
        end
        lcr_pkg::CP_CTRL_OFS: begin
          if (!lock0) begin // [R19] [R20]
            next_charge_pump_enable = wr_data[lcr_pkg::CHARGE_PUMP_ENABLE_BIT];
          end
        end
        lcr_pkg::PINF_OFS: begin
          if (!lock0) begin // [R19] [R20]
            next_pin_func = wr_data[lcr_pkg::PINF_LSB +: 3];
          end
        end
        lcr_pkg::DUTY_OFS: next_duty = wr_data;
        default: next_duty = duty;
      endcase
    end
    if (cs_rise && !SOFT_RST && !RESTART) begin
      next_lock1_act = lock1_act | next_lock1_bit; // [R2]
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      freq      <= lcr_pkg::HWC2_RST[lcr_pkg::FREQ_LSB +: 3];
      peak      <= lcr_pkg::HWC2_RST[lcr_pkg::PEAK_BIT];
      spread    <= lcr_pkg::HWC2_RST[lcr_pkg::SPREAD_LSB +: 2];
      lock1_bit <= lcr_pkg::HWC2_RST[lcr_pkg::LOCK1_BIT];
      lock1_act <= 1'b0;
      lock0     <= lcr_pkg::LOCK0_RST;
      charge_pump_enable     <= lcr_pkg::CHARGE_PUMP_ENABLE_RST;
      pin_func  <= lcr_pkg::PINF_RST;
      duty      <= lcr_pkg::DUTY_RST;
    end else begin
      freq      <= next_freq;
      peak      <= next_peak;
      spread    <= next_spread;
      lock1_bit <= next_lock1_bit;
      lock1_act <= next_lock1_act;
      lock0     <= next_lock0;
      charge_pump_enable     <= next_charge_pump_enable;
      pin_func  <= next_pin_func;
      duty      <= next_duty;
    end
  end
  assign HW_CFG.switching_freq_sel          = freq;
  assign HW_CFG.main_reg_peak_threshold_sel = peak;
  assign HW_CFG.spread_mod_freq_sel         = spread;
  assign CHARGE_PUMP_ENABLE                 = charge_pump_enable;
  assign PIN_FUNC                           = pin_func;
  assign LOCK0_SET                          = lock0;
  assign LOCK1_ACTIVE                       = lock1_act;
  // ===========================================================
  // pwm: 255 steps per period, duty taken at period end
  logic [15:0] step_div, next_step_div;
  logic [7:0]  pwm_cnt, next_pwm_cnt;
  logic [7:0]  duty_act, next_duty_act;
  logic        step;
  logic        pwm_on;
  assign step = step_div == 16'(PWM_STEP_CYCLES - 1);
  always_comb begin
    next_step_div = step ? 16'h0000 : step_div + 16'h0001;
    next_pwm_cnt  = pwm_cnt;
    next_duty_act = duty_act;
    if (step) begin
      if (pwm_cnt == lcr_pkg::PWM_LAST) begin
        next_pwm_cnt  = 8'h00;
        next_duty_act = duty; // [R17]
      end else begin
        next_pwm_cnt = pwm_cnt + 8'h01;
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      step_div <= 16'h0000;
      pwm_cnt  <= 8'h00;
      duty_act <= lcr_pkg::DUTY_RST;
    end else begin
      step_div <= next_step_div;
      pwm_cnt  <= next_pwm_cnt;
      duty_act <= next_duty_act;
    end
  end
  assign pwm_on = (duty_act == lcr_pkg::DUTY_FULL) ||
                  (pwm_cnt < duty_act); // [R16]
  // ===========================================================
  // wake filter and pin drive
  logic [8:0] filt_cnt, next_filt_cnt;
  logic       wake_lvl, next_wake_lvl;
  logic       wake_evt, next_wake_evt;
  logic       hs_on, next_hs_on;
  logic       ls_on, next_ls_on;
  always_comb begin
    next_filt_cnt = 9'h000;
    next_wake_lvl = wake_lvl;
    next_wake_evt = 1'b0;
    if (pin_sync[1] != wake_lvl) begin // [R12]
      if (filt_cnt == 9'(lcr_pkg::WAKE_FILT_CYC - 1)) begin
        next_wake_lvl = pin_sync[1];
        next_wake_evt = (pin_func == lcr_pkg::PF_WAKE) &&
                        (WAKE_ENABLE || FAIL_SAFE); // [R14]
      end else begin
        next_filt_cnt = filt_cnt + 9'h001;
      end
    end
    next_hs_on = 1'b0;
    next_ls_on = 1'b0;
    case (pin_func) // [R11] [R13]
      lcr_pkg::PF_FAIL0,
      lcr_pkg::PF_FAIL1,
      lcr_pkg::PF_FAIL2:   next_ls_on = FAIL_REQ;
      lcr_pkg::PF_TIMER_HS: next_hs_on = TIMER_ON;
      lcr_pkg::PF_PWM_LS:  next_ls_on = pwm_on;
      lcr_pkg::PF_PWM_HS:  next_hs_on = pwm_on;
      default:             next_hs_on = 1'b0;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      filt_cnt <= 9'h000;
      wake_lvl <= 1'b0;
      wake_evt <= 1'b0;
      hs_on    <= 1'b0;
      ls_on    <= 1'b0;
    end else begin
      filt_cnt <= next_filt_cnt;
      wake_lvl <= next_wake_lvl;
      wake_evt <= next_wake_evt;
      hs_on    <= next_hs_on;
      ls_on    <= next_ls_on;
    end
  end
  assign WAKE_LEVEL = wake_lvl;
  assign WAKE_EVENT = wake_evt;
  assign PIN_HS_ON  = hs_on;
  assign PIN_LS_ON  = ls_on;
endmodule // lcr_config_regs

//--- dv/lcr_config_regs_sva.sv
// assertion checker for the lockable configuration registers
`timescale 1ns/10ps
module lcr_config_regs_sva (
  input wire logic                 SYS_CLK,
  input wire logic                 SYS_RST,
  input wire logic                 SOFT_RST,
  input wire logic                 RESTART,
  input wire logic                 SPI_CS_N,
  input wire logic                 SPI_SDO_OE,
  input wire logic                 FAIL_REQ,
  input wire logic                 TIMER_ON,
  input wire logic                 FAIL_SAFE,
  input wire logic                 WAKE_ENABLE,
  input wire lcr_pkg::lcr_hw_cfg_s HW_CFG,
  input wire logic                 CHARGE_PUMP_ENABLE,
  input wire logic [2:0]           PIN_FUNC,
  input wire logic                 LOCK0_SET,
  input wire logic                 LOCK1_ACTIVE,
  input wire logic                 PIN_HS_ON,
  input wire logic                 PIN_LS_ON,
  input wire logic                 WAKE_EVENT
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence s_fail_mode;
    PIN_FUNC < 3'h3 ##1 PIN_FUNC < 3'h3;
  endsequence
  sequence s_timer_mode;
    PIN_FUNC == 3'h3 ##1 PIN_FUNC == 3'h3;
  endsequence
  sequence s_off_mode;
    PIN_FUNC[2:1] == 2'b10 ##1 PIN_FUNC[2:1] == 2'b10;
  endsequence
  // ==========================================================
  // properties
  property p_lock1_sticky;
    LOCK1_ACTIVE |=> LOCK1_ACTIVE;
  endproperty
  a_lock1_sticky: assert property (p_lock1_sticky)
    else $error("level-1 lock released");
  property p_hw_frozen;
    LOCK1_ACTIVE |=> $stable(HW_CFG);
  endproperty
  a_hw_frozen: assert property (p_hw_frozen)
    else $error("locked hw config changed");
  property p_lock1_on_cs;
    $rose(LOCK1_ACTIVE) |-> SPI_CS_N && $past(SPI_CS_N);
  endproperty
  a_lock1_on_cs: assert property (p_lock1_on_cs)
    else $error("lock engaged inside a frame");
  property p_lock0_hold;
    LOCK0_SET && !RESTART |=> $stable({CHARGE_PUMP_ENABLE, PIN_FUNC});
  endproperty
  a_lock0_hold: assert property (p_lock0_hold)
    else $error("level-0 locked field changed");
  property p_fail_pin;
    s_fail_mode |-> PIN_LS_ON == $past(FAIL_REQ) && !PIN_HS_ON;
  endproperty
  a_fail_pin: assert property (p_fail_pin)
    else $error("fail output drive wrong");
  property p_timer_pin;
    s_timer_mode |-> PIN_HS_ON == $past(TIMER_ON) && !PIN_LS_ON;
  endproperty
  a_timer_pin: assert property (p_timer_pin)
    else $error("timer high side drive wrong");
  property p_off_pin;
    s_off_mode |-> !PIN_HS_ON && !PIN_LS_ON;
  endproperty
  a_off_pin: assert property (p_off_pin)
    else $error("pin driven while off or wake");
  property p_wake_src;
    WAKE_EVENT |-> $past(PIN_FUNC) == 3'h5
      && ($past(WAKE_ENABLE) || $past(FAIL_SAFE));
  endproperty
  a_wake_src: assert property (p_wake_src)
    else $error("wake event without wake source");
  property p_restart_pin;
    RESTART && !SOFT_RST && (PIN_FUNC == 3'h3 || PIN_FUNC[2:1] == 2'b11)
      |=> PIN_FUNC == 3'h4;
  endproperty
  a_restart_pin: assert property (p_restart_pin)
    else $error("restart left switch function");
  property p_soft_free;
    SOFT_RST && !LOCK0_SET |=> !CHARGE_PUMP_ENABLE && PIN_FUNC == 3'h0;
  endproperty
  a_soft_free: assert property (p_soft_free)
    else $error("soft reset kept unlocked fields");
  property p_sdo_oe_follow;
    $changed(SPI_CS_N) |-> ##3 (SPI_SDO_OE == !$past(SPI_CS_N, 3));
  endproperty
  a_sdo_oe_follow: assert property (p_sdo_oe_follow)
    else $error("serial output enable not following select");
endmodule // lcr_config_regs_sva

bind lcr_config_regs lcr_config_regs_sva i_sva (.SYS_CLK, .SYS_RST,
  .SOFT_RST, .RESTART, .SPI_CS_N, .SPI_SDO_OE, .FAIL_REQ, .TIMER_ON,
  .FAIL_SAFE, .WAKE_ENABLE, .HW_CFG, .CHARGE_PUMP_ENABLE, .PIN_FUNC,
  .LOCK0_SET, .LOCK1_ACTIVE, .PIN_HS_ON, .PIN_LS_ON, .WAKE_EVENT);

//--- dv/lcr_spi_host.sv
// serial host model that frames register reads and writes
`timescale 1ns/10ps
module lcr_spi_host (
  input  wire logic       clk,
  input  wire logic       sdo,
  output logic            cs_n,
  output logic            sck,
  output logic            sdi,
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  // ==========================================================
  // frame driver, sck idles low outside frames
  localparam int HALF = 8;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  task automatic xfer(input logic [6:0] a, input logic w,
                      input logic [7:0] d);
    logic [15:0] frm;
    frm = {d, w, a};
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      sdi = frm[i];
      repeat (HALF) @(negedge clk);
      if (i > 7) rd_data[i-8] = sdo;
      sck = 1'b1;
      repeat (HALF) @(negedge clk);
      sck = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    sdi = ~sdi;
    rd_valid = !w;
    @(negedge clk);
    rd_valid = 1'b0;
    repeat (HALF) @(negedge clk);
  endtask
endmodule // lcr_spi_host

//--- dv/lockable_config_registers_test.sv
// self-checking bench for the lockable configuration registers
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module lockable_config_registers_test;
  logic sys_clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, restart = 1'b0;
  logic pin_in = 1'b0, fail_req = 1'b0, timer_on = 1'b0;
  logic fail_safe = 1'b0, wake_enable = 1'b0;
  logic cs_n, sck, sdi, sdo, rd_valid, charge_pump_enable, lock0, lock1;
  logic hs_on, ls_on, wake_level, wake_event;
  logic [7:0] rd_data, w, ev;
  logic [2:0] pin_func;
  lcr_pkg::lcr_hw_cfg_s hw_cfg;
  logic [7:0] exp_q[$];
  int miscompares = 0, checks_done = 0, wake_seen = 0;

  lcr_spi_host i_host (.clk(sys_clk), .sdo(sdo), .cs_n(cs_n), .sck(sck),
    .sdi(sdi), .rd_valid(rd_valid), .rd_data(rd_data));
  lcr_config_regs #(.PWM_STEP_CYCLES(2)) i_dut (.SYS_CLK(sys_clk),
    .SYS_RST(sys_rst), .SOFT_RST(soft_rst), .RESTART(restart),
    .SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_SDI(sdi), .SPI_SDO(sdo),
    .SPI_SDO_OE(), .PIN_IN(pin_in), .FAIL_REQ(fail_req),
    .TIMER_ON(timer_on), .FAIL_SAFE(fail_safe), .WAKE_ENABLE(wake_enable),
    .HW_CFG(hw_cfg), .CHARGE_PUMP_ENABLE(charge_pump_enable), .PIN_FUNC(pin_func),
    .LOCK0_SET(lock0), .LOCK1_ACTIVE(lock1), .PIN_HS_ON(hs_on),
    .PIN_LS_ON(ls_on), .WAKE_LEVEL(wake_level), .WAKE_EVENT(wake_event));

  // ==========================================================
  // clock, random pin requests, result monitors
  always #20 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    fail_req <= 1'($urandom);
    timer_on <= 1'($urandom);
  end
  always @(posedge sys_clk) if (wake_event === 1'b1) wake_seen++;
  always @(posedge rd_valid) begin
    ev = exp_q.pop_front();
    `CHK("read data", ev, rd_data)
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.xfer(a, 1'b0, 8'h00);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    idle(60000);
    miscompares++;
    tally_and_finish;
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h49a0a44b));
    idle(6);
    sys_rst = 1'b0;
    idle(4);
    rd(lcr_pkg::HWC2_OFS, lcr_pkg::HWC2_RST);
    rd(lcr_pkg::PINF_OFS, 8'h00);
    rd(7'h20, 8'h00);
    for (int i = 0; i < 8; i++) begin
      w = {3'(i), i[0], i[1:0], 2'b10};
      wr(lcr_pkg::HWC2_OFS, w);
      `CHK("hw cfg", w[7:2], hw_cfg)
      rd(lcr_pkg::HWC2_OFS, w & 8'hfc);
    end
    w = 8'($urandom);
    wr(lcr_pkg::DUTY_OFS, w);
    rd(lcr_pkg::DUTY_OFS, w);
    wr(lcr_pkg::DUTY_OFS, 8'hff);
    for (int i = 0; i < 8; i++) begin
      wr(lcr_pkg::PINF_OFS, {5'h1f, 3'(i)});
      rd(lcr_pkg::PINF_OFS, {5'h00, 3'(i)});
    end
    idle(600);
    `CHK("pwm high on", 2'b10, {hs_on, ls_on})
    wr(lcr_pkg::DUTY_OFS, 8'h00);
    idle(600);
    `CHK("pwm off", 2'b00, {hs_on, ls_on})
    wr(lcr_pkg::DUTY_OFS, 8'hff);
    wr(lcr_pkg::PINF_OFS, 8'h06);
    idle(600);
    `CHK("pwm low on", 2'b01, {hs_on, ls_on})
    wr(lcr_pkg::CP_CTRL_OFS, 8'h01);
    wr(lcr_pkg::HWC1_OFS, 8'h08);
    wr(lcr_pkg::PINF_OFS, 8'h05);
    wr(lcr_pkg::CP_CTRL_OFS, 8'h00);
    `CHK("lock0", 5'h1e, {lock0, charge_pump_enable, pin_func})
    pulse(soft_rst);
    `CHK("soft lock0", 5'h0e, {lock0, charge_pump_enable, pin_func})
    pulse(restart);
    `CHK("restart pin", 3'h4, pin_func)
    pulse(soft_rst);
    `CHK("soft free", 5'h00, {lock0, charge_pump_enable, pin_func})
    wake_enable = 1'b1;
    wr(lcr_pkg::PINF_OFS, 8'h05);
    pin_in = 1'b1;
    idle(100);
    pin_in = 1'b0;
    idle(450);
    `CHK("wake glitch", 0, wake_seen)
    pin_in = 1'b1;
    idle(450);
    `CHK("wake level", 1'b1, wake_level)
    wake_enable = 1'b0;
    fail_safe = 1'b1;
    pin_in = 1'b0;
    idle(450);
    fail_safe = 1'b0;
    pin_in = 1'b1;
    idle(450);
    `CHK("wake count", 2, wake_seen)
    wr(lcr_pkg::HWC2_OFS, 8'h61);
    `CHK("lock1 on", 1'b1, lock1)
    wr(lcr_pkg::HWC2_OFS, 8'h00);
    pulse(soft_rst);
    rd(lcr_pkg::HWC2_OFS, 8'h61);
    `CHK("lock1 kept", 1'b1, lock1)
    wr(lcr_pkg::PINF_OFS, 8'h04);
    `CHK("pin unlocked", 3'h4, pin_func)
    sys_rst = 1'b1;
    idle(3);
    sys_rst = 1'b0;
    idle(4);
    `CHK("por lock1", 1'b0, lock1)
    rd(lcr_pkg::HWC2_OFS, lcr_pkg::HWC2_RST);
    tally_and_finish;
  end
endmodule // lockable_config_registers_test

//--- include/lcr_pkg.sv
// constants, types and register map of the lockable configuration registers
package lcr_pkg;

  // ===========================================================
  // register offsets (7-bit serial address)
  localparam logic [6:0] HWC1_OFS    = 7'h0e;
  localparam logic [6:0] HWC2_OFS    = 7'h0f;
  localparam logic [6:0] PINF_OFS    = 7'h17;
  localparam logic [6:0] DUTY_OFS    = 7'h18;
  localparam logic [6:0] CP_CTRL_OFS = 7'h04;

  // ===========================================================
  // field positions
  localparam int LOCK0_BIT  = 3;
  localparam int LOCK1_BIT  = 0;
  localparam int FREQ_LSB   = 5;
  localparam int PEAK_BIT   = 4;
  localparam int SPREAD_LSB = 2;
  localparam int CHARGE_PUMP_ENABLE_BIT  = 0;
  localparam int PINF_LSB   = 0;

  // ===========================================================
  // reset values
  localparam logic [7:0] HWC2_RST  = 8'h40;
  localparam logic [2:0] PINF_RST  = 3'h0;
  localparam logic [7:0] DUTY_RST  = 8'h00;
  localparam logic       LOCK0_RST = 1'b0;
  localparam logic       CHARGE_PUMP_ENABLE_RST = 1'b0;

  // ===========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_FILT_NS  = 16000;
  localparam int WAKE_FILT_CYC =
    (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPI_FRAME_BITS = 16;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] PWM_LAST  = 8'hfe;

  // ===========================================================
  // types
  typedef enum logic [2:0] {
    PF_FAIL0   = 3'b000,
    PF_FAIL1   = 3'b001,
    PF_FAIL2   = 3'b010,
    PF_TIMER_HS = 3'b011,
    PF_OFF     = 3'b100,
    PF_WAKE    = 3'b101,
    PF_PWM_LS  = 3'b110,
    PF_PWM_HS  = 3'b111
  } lcr_pin_func_e;

  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,
    SP_SHIFT = 2'b01,
    SP_ERR   = 2'b10
  } lcr_spi_st_e;

  typedef struct packed {
    logic [2:0] switching_freq_sel;
    logic       main_reg_peak_threshold_sel;
    logic [1:0] spread_mod_freq_sel;
  } lcr_hw_cfg_s;

endpackage
